// ### src/efctm_regs.sv
/*
 Register slice: bandpass B1 low byte, lowpass A2/B1 split coefficients and
 the test signal select register, with decoded test pin and export controls.
 Assumes a single AHB-Lite master, single word transfers, one clock.
*/
// Added by the designer: the AHB-Lite slave port.
`default_nettype none
// Functional notes
// - Bandpass B1 low byte, full read/write, resets zero
// - Lowpass A2 high: bits 6..0 writable, bit7 zero
// - Lowpass A2 low byte fully read/write
// - Lowpass B1 high: bits 6..0 writable, bit7 zero
// - Lowpass B1 low byte fully read/write
// - Lowpass and test select registers reset zero
// - Bits 7..5 choose test pin source
// - Codes 0..3 analog, codes 4..7 digital
// - Bit3 picks 8-bit/1us or 12-bit/2us samples
// - Format only applies for tap codes 1..4
// - Bits 2..0 choose exported datapath tap
// - Test select bit4 reserved, reads zero
module efctm_regs (
    input wire logic CLOCK, // System clock, 10 MHz
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic HSEL, // Slave select
    input wire logic [31:0] HADDR, // Byte address
    input wire logic [1:0] HTRANS, // Transfer type
    input wire logic HWRITE, // Write when high
    input wire logic [2:0] HSIZE, // Transfer size
    input wire logic [31:0] HWDATA, // Write data
    input wire logic HREADY, // Bus ready in
    output logic [31:0] HRDATA, // Read data, registered
    output logic HREADYOUT, // Always ready
    output logic HRESP, // Always OKAY
    output logic [7:0] BANDPASS_B1_LOW, // Coefficient byte
    output logic [14:0] LOWPASS_A2, // Lowpass A2 coefficient
    output logic [14:0] LOWPASS_B1, // Lowpass B1 coefficient
    output efctm_pkg::efctm_pin_t TEST_PIN_CTRL, // Decoded test pin source
    output efctm_pkg::efctm_export_t EXPORT_CTRL // Decoded export settings
);
    logic [7:0] bp_b1_lo_ff;
    logic [7:0] a2_hi_ff;
    logic [7:0] a2_lo_ff;
    logic [7:0] b1_hi_ff;
    logic [7:0] b1_lo_ff;
    logic [7:0] tsel_ff;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [31:0] rdata_ff;
    logic [7:0] wbyte;
    logic [7:0] rd_idx;
    logic rd_hit;
    logic [7:0] rd_val;
    logic addr_phase;

    assign addr_phase = HSEL && HREADY && HTRANS[1];
    assign wbyte = HWDATA[7:0];
    assign rd_idx = HADDR[9:2];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_ff;

    // Write data arrives one cycle after the address, so latch the index
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= addr_phase && HWRITE && (HADDR[31:10] == 22'h000000);
            wr_idx_ff <= HADDR[9:2];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            bp_b1_lo_ff <= efctm_pkg::RST_BYTE;
            a2_hi_ff <= efctm_pkg::RST_BYTE;
            a2_lo_ff <= efctm_pkg::RST_BYTE;
            b1_hi_ff <= efctm_pkg::RST_BYTE;
            b1_lo_ff <= efctm_pkg::RST_BYTE;
            tsel_ff <= efctm_pkg::RST_BYTE;
        end
        else if (wr_pend_ff)
        begin
            unique case (wr_idx_ff)
                efctm_pkg::IDX_BANDPASS_B1_LOW: bp_b1_lo_ff <= wbyte;
                efctm_pkg::IDX_LOWPASS_A2_HIGH:
                    a2_hi_ff <= wbyte & efctm_pkg::HIGH_BYTE_MASK;
                efctm_pkg::IDX_LOWPASS_A2_LOW: a2_lo_ff <= wbyte;
                efctm_pkg::IDX_LOWPASS_B1_HIGH:
                    b1_hi_ff <= wbyte & efctm_pkg::HIGH_BYTE_MASK;
                efctm_pkg::IDX_LOWPASS_B1_LOW: b1_lo_ff <= wbyte;
                efctm_pkg::IDX_TEST_SIGNAL_SELECT:
                    tsel_ff <= wbyte & efctm_pkg::TEST_SEL_MASK;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        unique case (rd_idx)
            efctm_pkg::IDX_BANDPASS_B1_LOW: rd_val = bp_b1_lo_ff;
            efctm_pkg::IDX_LOWPASS_A2_HIGH: rd_val = a2_hi_ff;
            efctm_pkg::IDX_LOWPASS_A2_LOW: rd_val = a2_lo_ff;
            efctm_pkg::IDX_LOWPASS_B1_HIGH: rd_val = b1_hi_ff;
            efctm_pkg::IDX_LOWPASS_B1_LOW: rd_val = b1_lo_ff;
            efctm_pkg::IDX_TEST_SIGNAL_SELECT: rd_val = tsel_ff;
            default:
            begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
        if (HADDR[31:10] != 22'h000000)
        begin
            rd_hit = 1'b0;
        end
    end

    // Unmapped reads return zero; a read right after a write to the same
    // register sees the old value, since the write lands in the same edge
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            rdata_ff <= 32'h00000000;
        end
        else if (addr_phase && !HWRITE)
        begin
            rdata_ff <= rd_hit ? {24'h000000, rd_val} : 32'h00000000;
        end
    end

    assign BANDPASS_B1_LOW = bp_b1_lo_ff;
    assign LOWPASS_A2 = {a2_hi_ff[6:0], a2_lo_ff};
    assign LOWPASS_B1 = {b1_hi_ff[6:0], b1_lo_ff};

    logic [2:0] pin_src;
    logic [2:0] tap;
    logic tap_active;
    logic fmt_wide;

    assign pin_src = tsel_ff[efctm_pkg::TPIN_LSB +: 3];
    assign tap = tsel_ff[efctm_pkg::TAP_LSB +: 3];
    // Codes 5..7 are unused, so they export nothing
    assign tap_active = (tap >= efctm_pkg::TAP_LOWPASS)
        && (tap <= efctm_pkg::TAP_CONVERTER);
    assign fmt_wide = tap_active && tsel_ff[efctm_pkg::FMT_BIT];

    always_comb
    begin
        TEST_PIN_CTRL.pin_src = pin_src;
        TEST_PIN_CTRL.pin_digital = pin_src[2];
        TEST_PIN_CTRL.pin_analog = !pin_src[2];
        TEST_PIN_CTRL.pin_valid = (pin_src == efctm_pkg::TPIN_GND)
            || (pin_src == efctm_pkg::TPIN_FRONT_END)
            || (pin_src == efctm_pkg::TPIN_CLK_8M)
            || (pin_src == efctm_pkg::TPIN_SAMPLE_CLK);
        EXPORT_CTRL.tap = tap_active ? tap : efctm_pkg::TAP_OFF;
        EXPORT_CTRL.active = tap_active;
        EXPORT_CTRL.wide = fmt_wide;
        if (!tap_active)
        begin
            EXPORT_CTRL.width = 8'h00;
            EXPORT_CTRL.period_cycles = 8'h00;
        end
        else if (fmt_wide)
        begin
            EXPORT_CTRL.width = 8'(efctm_pkg::SAMPLE_W_WIDE);
            EXPORT_CTRL.period_cycles = 8'(efctm_pkg::CYC_WIDE);
        end
        else
        begin
            EXPORT_CTRL.width = 8'(efctm_pkg::SAMPLE_W_NARROW);
            EXPORT_CTRL.period_cycles = 8'(efctm_pkg::CYC_NARROW);
        end
    end

    property p_high_bit7_zero;
        @(posedge CLOCK) disable iff (SYS_RST) !a2_hi_ff[7] && !b1_hi_ff[7];
    endproperty
    a_high_bit7_zero: assert property (p_high_bit7_zero) else $error("high bit7 set");

    property p_b1_high_bit7;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_LOWPASS_B1_HIGH
            |=> b1_hi_ff == ($past(HWDATA[7:0]) & 8'h7F);
    endproperty
    a_b1_high_bit7: assert property (p_b1_high_bit7) else $error("b1 high write wrong");

    property p_a2_low_write;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_LOWPASS_A2_LOW
            |=> a2_lo_ff == $past(HWDATA[7:0]);
    endproperty
    a_a2_low_write: assert property (p_a2_low_write) else $error("a2 low write lost");

    property p_b1_low_write;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_LOWPASS_B1_LOW
            |=> b1_lo_ff == $past(HWDATA[7:0]);
    endproperty
    a_b1_low_write: assert property (p_b1_low_write) else $error("b1 low write lost");

    property p_bp_write;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_BANDPASS_B1_LOW
            |=> bp_b1_lo_ff == $past(HWDATA[7:0]);
    endproperty
    a_bp_write: assert property (p_bp_write) else $error("bandpass write lost");

    property p_reset_zero;
        @(posedge CLOCK) SYS_RST |=> LOWPASS_A2 == 15'h0000 && LOWPASS_B1 == 15'h0000
            && tsel_ff == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

    property p_bit4_zero;
        @(posedge CLOCK) disable iff (SYS_RST) !tsel_ff[4];
    endproperty
    a_bit4_zero: assert property (p_bit4_zero) else $error("test select bit4 set");

    property p_digital_code;
        @(posedge CLOCK) disable iff (SYS_RST)
            TEST_PIN_CTRL.pin_digital == (TEST_PIN_CTRL.pin_src >= 3'h4);
    endproperty
    a_digital_code: assert property (p_digital_code) else $error("analog/digital wrong");

    property p_fmt_gated;
        @(posedge CLOCK) disable iff (SYS_RST)
            (tap == 3'h0 || tap > 3'h4) |-> !EXPORT_CTRL.wide && EXPORT_CTRL.width == 8'h00;
    endproperty
    a_fmt_gated: assert property (p_fmt_gated) else $error("format applied while off");

    property p_wide_period;
        @(posedge CLOCK) disable iff (SYS_RST)
            EXPORT_CTRL.wide |-> EXPORT_CTRL.width == 8'h0C && EXPORT_CTRL.period_cycles == 8'h14;
    endproperty
    a_wide_period: assert property (p_wide_period) else $error("wide format wrong");

    property p_tap_follow;
        @(posedge CLOCK) disable iff (SYS_RST)
            EXPORT_CTRL.active |-> EXPORT_CTRL.tap == tsel_ff[2:0];
    endproperty
    a_tap_follow: assert property (p_tap_follow) else $error("tap mismatch");

    property p_pin_src;
        @(posedge CLOCK) disable iff (SYS_RST) TEST_PIN_CTRL.pin_src == tsel_ff[7:5];
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("pin source mismatch");

    property p_reserved_ignored;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_TEST_SIGNAL_SELECT
            |=> tsel_ff == ($past(HWDATA[7:0]) & 8'hEF);
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored) else $error("bit4 kept");

    property p_a2_high_write;
        @(posedge CLOCK) disable iff (SYS_RST)
            wr_pend_ff && wr_idx_ff == efctm_pkg::IDX_LOWPASS_A2_HIGH
            |=> a2_hi_ff == ($past(HWDATA[7:0]) & efctm_pkg::HIGH_BYTE_MASK);
    endproperty
    a_a2_high_write: assert property (p_a2_high_write) else $error("a2 high write bad");

    property p_rd_upper;
        @(posedge CLOCK) disable iff (SYS_RST) HRDATA[31:8] == 24'h000000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");

    property p_rd_bit4_zero;
        @(posedge CLOCK) disable iff (SYS_RST)
            addr_phase && !HWRITE && rd_idx == efctm_pkg::IDX_TEST_SIGNAL_SELECT
            |=> !HRDATA[4];
    endproperty
    a_rd_bit4_zero: assert property (p_rd_bit4_zero) else $error("bit4 read set");

    property p_rd_high_bit7;
        @(posedge CLOCK) disable iff (SYS_RST)
            addr_phase && !HWRITE && (rd_idx == efctm_pkg::IDX_LOWPASS_A2_HIGH
            || rd_idx == efctm_pkg::IDX_LOWPASS_B1_HIGH) |=> !HRDATA[7];
    endproperty
    a_rd_high_bit7: assert property (p_rd_high_bit7) else $error("bit7 read set");

    property p_narrow_fmt;
        @(posedge CLOCK) disable iff (SYS_RST)
            EXPORT_CTRL.active && !EXPORT_CTRL.wide
            |-> EXPORT_CTRL.width == 8'h08 && EXPORT_CTRL.period_cycles == 8'h0A;
    endproperty
    a_narrow_fmt: assert property (p_narrow_fmt) else $error("narrow format wrong");

    property p_pin_valid;
        @(posedge CLOCK) disable iff (SYS_RST)
            TEST_PIN_CTRL.pin_valid == !TEST_PIN_CTRL.pin_src[1];
    endproperty
    a_pin_valid: assert property (p_pin_valid) else $error("pin valid wrong");
endmodule
`default_nettype wire

// ### src/efctm_pkg.sv
/*
 Package for the echo filter coefficient and test select register slice:
 register offsets, field positions, reset values and selector codes.
 Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
*/
`default_nettype none
package efctm_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_BANDPASS_B1_LOW = 8'h46;
    localparam logic [7:0] IDX_LOWPASS_A2_HIGH = 8'h47;
    localparam logic [7:0] IDX_LOWPASS_A2_LOW = 8'h48;
    localparam logic [7:0] IDX_LOWPASS_B1_HIGH = 8'h49;
    localparam logic [7:0] IDX_LOWPASS_B1_LOW = 8'h4A;
    localparam logic [7:0] IDX_TEST_SIGNAL_SELECT = 8'h4B;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] HIGH_BYTE_MASK = 8'h7F;
    localparam logic [7:0] TEST_SEL_MASK = 8'hEF;

    localparam int TPIN_LSB = 5;
    localparam int FMT_BIT = 3;
    localparam int TAP_LSB = 0;

    localparam logic [2:0] TPIN_GND = 3'h0;
    localparam logic [2:0] TPIN_FRONT_END = 3'h1;
    localparam logic [2:0] TPIN_CLK_8M = 3'h4;
    localparam logic [2:0] TPIN_SAMPLE_CLK = 3'h5;

    localparam logic [2:0] TAP_OFF = 3'h0;
    localparam logic [2:0] TAP_LOWPASS = 3'h1;
    localparam logic [2:0] TAP_RECTIFIER = 3'h2;
    localparam logic [2:0] TAP_BANDPASS = 3'h3;
    localparam logic [2:0] TAP_CONVERTER = 3'h4;

    localparam int SAMPLE_W_NARROW = 8;
    localparam int SAMPLE_W_WIDE = 12;
    localparam int PERIOD_NARROW_US = 1;
    localparam int PERIOD_WIDE_US = 2;
    localparam int CLK_MHZ = 10;
    localparam int CYC_NARROW = PERIOD_NARROW_US * CLK_MHZ;
    localparam int CYC_WIDE = PERIOD_WIDE_US * CLK_MHZ;

    typedef struct packed {
        logic [2:0] pin_src;
        logic pin_analog;
        logic pin_digital;
        logic pin_valid;
    } efctm_pin_t;

    typedef struct packed {
        logic [2:0] tap;
        logic active;
        logic wide;
        logic [7:0] width;
        logic [7:0] period_cycles;
    } efctm_export_t;
endpackage
`default_nettype wire

// ### test/efctm_regs_bench.sv
/*
 Self-checking bench for the coefficient and test select register slice.
 Acts as the only AHB-Lite master; the slave's HREADYOUT is fed back as HREADY.
*/
`default_nettype none
module efctm_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [7:0] BANDPASS_B1_LOW;
    logic [14:0] LOWPASS_A2, LOWPASS_B1;
    efctm_pkg::efctm_pin_t TEST_PIN_CTRL;
    efctm_pkg::efctm_export_t EXPORT_CTRL;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [7:0] msk [6] = '{8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hEF};

    efctm_regs i_efctm_regs (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .BANDPASS_B1_LOW(BANDPASS_B1_LOW), .LOWPASS_A2(LOWPASS_A2),
        .LOWPASS_B1(LOWPASS_B1), .TEST_PIN_CTRL(TEST_PIN_CTRL), .EXPORT_CTRL(EXPORT_CTRL));

    initial
    begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits for hready high at a rising edge; a stuck bus ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (HREADYOUT !== 1'b1 && n < 50);
        if (HREADYOUT !== 1'b1)
        begin
            num_errors++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        wait_rdy();
        HTRANS <= 2'h0;
        HWDATA <= {24'h000000, d};
        wait_rdy();
        rd = HRDATA;
        chk("hresp", 32'h0, {31'h0, HRESP});
        @(posedge CLOCK);
    endtask

    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h000000, idx, 2'h0};
    endfunction

    task automatic t_regs(input logic [7:0] p);
        for (int i = 0; i < 6; i++)
            xfer(ba(8'h46 + i[7:0]), 1'b1, p);
        for (int i = 0; i < 6; i++)
        begin
            xfer(ba(8'h46 + i[7:0]), 1'b0, 8'h00);
            chk("readback", {24'h0, p & msk[i]}, rd);
        end
        chk("bp_b1", {24'h0, p}, {24'h0, BANDPASS_B1_LOW});
        chk("lp_a2", {17'h0, p[6:0], p}, {17'h0, LOWPASS_A2});
        chk("lp_b1", {17'h0, p[6:0], p}, {17'h0, LOWPASS_B1});
    endtask

    task automatic t_unmapped;
        xfer(ba(8'h4C), 1'b1, 8'hFF);
        xfer(ba(8'h4C), 1'b0, 8'h00);
        chk("unmapped", 32'h0, rd);
        // Alias above the register window must not reach the bandpass byte
        xfer(32'h00000518, 1'b1, 8'h12);
        xfer(32'h00000518, 1'b0, 8'h00);
        chk("alias_read", 32'h0, rd);
        // The bandpass byte still holds the last pattern written to it
        xfer(ba(8'h46), 1'b0, 8'h00);
        chk("alias", 32'h00000035, rd);
        chk("alias_bp", 32'h00000035, {24'h0, BANDPASS_B1_LOW});
    endtask

    task automatic t_pin;
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            xfer(ba(8'h4B), 1'b1, {c, 5'h00});
            chk("pin_src", {29'h0, c}, {29'h0, TEST_PIN_CTRL.pin_src});
            chk("analog", {31'h0, c < 3'h4}, {31'h0, TEST_PIN_CTRL.pin_analog});
            chk("digital", {31'h0, c >= 3'h4}, {31'h0, TEST_PIN_CTRL.pin_digital});
            chk("pin_ok", {31'h0, c[1] == 1'b0}, {31'h0, TEST_PIN_CTRL.pin_valid});
        end
    endtask

    task automatic t_tap;
        logic [2:0] t;
        logic f, act;
        for (int i = 0; i < 16; i++)
        begin
            t = i[2:0];
            f = i[3];
            act = t >= 3'h1 && t <= 3'h4;
            xfer(ba(8'h4B), 1'b1, {4'h0, f, t});
            chk("tap", {29'h0, act ? t : 3'h0}, {29'h0, EXPORT_CTRL.tap});
            chk("active", {31'h0, act}, {31'h0, EXPORT_CTRL.active});
            chk("wide", {31'h0, f & act}, {31'h0, EXPORT_CTRL.wide});
            // 1 us is 10 cycles and 2 us is 20 cycles at 10 MHz
            chk("width", act ? (f ? 32'h0C : 32'h08) : 32'h00, {24'h0, EXPORT_CTRL.width});
            chk("period", act ? (f ? 32'h14 : 32'h0A) : 32'h00,
                {24'h0, EXPORT_CTRL.period_cycles});
        end
    endtask

    // Reset in mid-run must clear values written before it
    task automatic t_reset;
        xfer(ba(8'h47), 1'b1, 8'h5A);
        xfer(ba(8'h4B), 1'b1, 8'hE9);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        chk("rst_a2", 32'h0, {17'h0, LOWPASS_A2});
        chk("rst_b1", 32'h0, {17'h0, LOWPASS_B1});
        chk("rst_bp", 32'h0, {24'h0, BANDPASS_B1_LOW});
        chk("rst_tap", 32'h0, {29'h0, EXPORT_CTRL.tap});
        chk("rst_pin", 32'h0, {29'h0, TEST_PIN_CTRL.pin_src});
        for (int i = 0; i < 6; i++)
        begin
            xfer(ba(8'h46 + i[7:0]), 1'b0, 8'h00);
            chk("rst_read", 32'h0, rd);
        end
    endtask

    initial
    begin
        SYS_RST = 1'b1;
        HSEL = 1'b1;
        HTRANS = 2'h0;
        HADDR = 32'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        repeat (12) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            xfer(ba(8'h46 + i[7:0]), 1'b0, 8'h00);
            chk("reset", 32'h0, rd);
        end
        t_regs(8'hFF);
        t_regs(8'h35);
        t_unmapped();
        t_pin();
        t_tap();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
